// file: pkg/pdr_consts.svh
/*
 * Constants of the port data register block: register selects, port
 * indices, implemented-pin masks and reset values.
 * Assumes inclusion by bare name from the port data register design file.
 */
`ifndef PDR_CONSTS_SVH
`define PDR_CONSTS_SVH

// port indices, first port to seventh
`define PDR_PORT_A 3'h0
`define PDR_PORT_B 3'h1
`define PDR_PORT_C 3'h2
`define PDR_PORT_D 3'h3
`define PDR_PORT_E 3'h4
`define PDR_PORT_F 3'h5
`define PDR_PORT_G 3'h6

// register selects within one port, address bits 3:0
`define PDR_SEL_PIN_INPUT     4'h0
`define PDR_SEL_OUTPUT_LATCH  4'h1
`define PDR_SEL_DIRECTION     4'h2
`define PDR_SEL_CONTROL       4'h3
`define PDR_SEL_DRIVE         4'h4
`define PDR_SEL_OUTPUT_CELL   4'h5
`define PDR_SEL_LOAD_BLOCK    4'h6
`define PDR_SEL_INPUT_CELL    4'h7
`define PDR_SEL_DRIVER_ENABLE 4'h8

// implemented pins per port
`define PDR_FULL_MASK 8'hFF
`define PDR_D_MASK    8'h0F

// reset values
`define PDR_RST_BYTE  8'h00
`define PDR_RST_CELLS 16'h0000
`define PDR_RST_INCEL 24'h000000

`endif

// file: pkg/pdr_pkg.sv
/*
 * Types of the port data register block: the register state record.
 * Assumes pdr_consts.svh is on the include path.
 */
package pdr_pkg;
	typedef logic [6:0][7:0] pdr_bytes_t;

	// whole register state of the block
	typedef struct packed {
		pdr_bytes_t  outLatch;
		pdr_bytes_t  direction;
		pdr_bytes_t  control;
		pdr_bytes_t  drive;
		logic [15:0] outCell;
		logic [15:0] loadBlock;
		logic [23:0] inCell;
		logic [7:0]  rdata;
	} pdr_state_t;
endpackage

// file: pkg/pdr_slice_if.sv
/*
 * Carrier between the register core and one port driver slice.
 * Assumes one instance per port, all signals combinational.
 */
interface pdr_slice_if;
	logic [7:0] latch;
	logic [7:0] dirBits;
	logic [7:0] oeTerm;
	logic [7:0] altSel;
	logic [7:0] altVal;
	logic [7:0] forceOe;
	logic [7:0] forceIn;
	logic [7:0] openDrain;
	logic [7:0] pinOut;
	logic [7:0] pinOe;
	logic [7:0] drvEn;

	modport core (output latch, dirBits, oeTerm, altSel, altVal, forceOe,
		forceIn, openDrain, input pinOut, pinOe, drvEn);
	modport slice (input latch, dirBits, oeTerm, altSel, altVal, forceOe,
		forceIn, openDrain, output pinOut, pinOe, drvEn);
endinterface

// file: logic/pdr_port_slice.sv
/*
 * One port's pin driver: picks the driven value, gates the driver and
 * applies open-drain behaviour for the pins the port implements.
 * Assumes the core fills the carrier; purely combinational.
 */
module pdr_port_slice #(
	parameter logic [7:0] PIN_MASK = 8'hFF
) (
	pdr_slice_if.slice sl
);
	logic [7:0] value;
	logic [7:0] drv;

	// value and driver gating
	always_comb begin
		value = (sl.altSel & sl.altVal) | (~sl.altSel & sl.latch);
		drv = ~sl.forceIn & (sl.forceOe | sl.dirBits | sl.oeTerm); // RULE_02
		drv = drv & PIN_MASK; // RULE_12
	end

	// open-drain pins only sink, released when high
	assign sl.pinOut = value & ~sl.openDrain & PIN_MASK; // RULE_11
	assign sl.pinOe  = drv & (~sl.openDrain | ~value);
	assign sl.drvEn  = drv; // RULE_08
endmodule

// file: logic/pdr_port_data.sv
/*
 * Port data registers of seven configurable I/O ports: pin read-back,
 * output latches, direction, control and drive registers, output and
 * input logic cells with load blocking, driver-enable status and the
 * alternate pin functions of each port.
 * Assumes host accesses are single-cycle strobes synchronous to clk, and
 * that pins and logic-array terms are synchronous to clk.
 */
//
// Behaviour
// RULE_01: pin input register returns the live pin level.
// RULE_02: latch drives pin when direction bit or array enable term is 1.
// RULE_03: output latch stores host writes and reads back stored value.
// RULE_04: output cell reads flip-flops; writes load unblocked bits.
// RULE_05: one load-block bit per cell; 1 blocks host load; resets 0.
// RULE_06: output cells and load block only on first two ports, block RW.
// RULE_07: input cells of first three ports capture pins, feed array, readable.
// RULE_08: driver-enable status is 1 when driving, 0 when tri-stated; open-drain pins released high still read 1.
// RULE_09: driver-enable status read-only on ports one, two, three, six.
// RULE_10: cell groups route to ports one and two; chip selects to three or six.
// RULE_11: third port fast slew per pin; first port open-drain per pin.
// RULE_12: fourth port has four pins, host I/O or direct array inputs.
// RULE_13: fourth port pins may serve strobe, clock, chip select, write high.
// RULE_14: chip select input high disables memories and the I/O registers.
// RULE_15: fifth port serial test port, standby supply pin, battery-on pin.
// RULE_16: non-multiplexed bus puts data low on port six, high on seven.
// RULE_17: ports five to seven output latched address; peripheral, reset modes.
// RULE_18: direction bit 1 makes output, 0 input; inputs after reset.
// RULE_19: control bit 0 host I/O, 1 latched address out; reset host I/O.
// RULE_20: reset pattern driven on six and seven in reset without bus cycle.
// RULE_21: host sets load block bits before partial output cell writes.
// RULE_22: bits of missing pins read zero and ignore writes.
`include "pdr_consts.svh"

module pdr_port_data
	import pdr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	// host register access
	input  wire logic [6:0]  hostAddr,
	input  wire logic        hostWrite,
	input  wire logic        hostRead,
	input  wire logic [7:0]  hostWdata,
	output logic      [7:0]  hostRdata,
	// pins, packed per port, first port at index 0
	input  wire pdr_bytes_t  pinIn,
	output pdr_bytes_t       pinOut,
	output pdr_bytes_t       pinOe,
	// logic-array side
	input  wire pdr_bytes_t  oeTerm,
	input  wire logic [15:0] cellNext,
	input  wire logic        cellClkEn,
	input  wire logic [23:0] inCellLoad,
	input  wire logic [7:0]  externalChipSelects,
	output logic      [23:0] inputCellBus,
	output logic      [15:0] outputCellBus,
	// per-pin configuration
	input  wire logic [7:0]  firstGroupRoute,
	input  wire logic [7:0]  secondGroupRoute,
	input  wire logic        chipSelectsToThird,
	input  wire logic        chipSelectsToSixth,
	input  wire logic [3:0]  dedicatedInputEn,
	input  wire logic        serialPortEn,
	input  wire logic        serialDataOut,
	input  wire logic        batteryStandbyEn,
	input  wire logic        batteryOnRouteEn,
	input  wire logic        batteryOnIndicator,
	input  wire logic        dataPortEn,
	input  wire logic        peripheralModeEn,
	input  wire logic        busDataDrive,
	input  wire logic [15:0] busDataOut,
	input  wire logic [15:0] latchedAddress,
	input  wire logic        resetPatternEn,
	input  wire logic        hostResetActive,
	input  wire logic        busCycleActive,
	input  wire logic [15:0] resetPattern,
	// derived outputs
	output logic      [15:0] busDataIn,
	output logic      [15:0] fastSlew,
	output logic             addressStrobe,
	output logic             logicClockInput,
	output logic             chipSelectHigh,
	output logic             highByteWriteEnable,
	output logic             memoryDisable,
	output logic      [2:0]  serialPortIn
);
	pdr_state_t st;
	pdr_state_t next_st;
	pdr_bytes_t drvEn;
	pdr_bytes_t altSel;
	pdr_bytes_t altVal;
	pdr_bytes_t forceOe;
	pdr_bytes_t forceIn;
	pdr_bytes_t openDrain;
	logic [2:0] selPort;
	logic [3:0] selReg;
	logic       regBlockOn;
	logic       dataPortOn;
	logic       patternOn;
	logic [7:0] portMask;
	logic [7:0] readVal;

	localparam logic [6:0][7:0] PORT_MASKS = {`PDR_FULL_MASK,
		`PDR_FULL_MASK, `PDR_FULL_MASK, `PDR_D_MASK, `PDR_FULL_MASK,
		`PDR_FULL_MASK, `PDR_FULL_MASK};

	assign selPort = hostAddr[6:4];
	assign selReg  = hostAddr[3:0];

	// port four dedicated inputs taken straight from the pins
	assign addressStrobe       = dedicatedInputEn[0] & pinIn[3][0]; // RULE_13
	assign logicClockInput     = dedicatedInputEn[1] & pinIn[3][1];
	assign chipSelectHigh      = dedicatedInputEn[2] & pinIn[3][2];
	assign highByteWriteEnable = dedicatedInputEn[3] & pinIn[3][3];

	// chip select high shuts memories and the register block
	assign memoryDisable = chipSelectHigh; // RULE_14
	assign regBlockOn    = ~chipSelectHigh; // RULE_14

	// sixth and seventh ports as data port or reset pattern source
	assign dataPortOn = dataPortEn | peripheralModeEn;
	assign patternOn  = resetPatternEn & hostResetActive
		& ~busCycleActive; // RULE_20
	assign busDataIn    = {pinIn[6], pinIn[5]}; // RULE_16
	assign serialPortIn = serialPortEn ? pinIn[4][2:0] : 3'h0; // RULE_15

	// slew options exist on the third and sixth ports only
	assign fastSlew = {st.drive[5], st.drive[2]}; // RULE_11

	// logic cells face the logic array
	assign inputCellBus  = st.inCell; // RULE_07
	assign outputCellBus = st.outCell;
	assign hostRdata     = st.rdata;

	// alternate functions of each pin
	always_comb begin
		altSel    = '0;
		altVal    = '0;
		forceOe   = '0;
		forceIn   = '0;
		openDrain = '0;
		// first and second ports carry the output cell groups
		altSel[0] = firstGroupRoute; // RULE_10
		altVal[0] = st.outCell[7:0];
		altSel[1] = secondGroupRoute;
		altVal[1] = st.outCell[15:8];
		// chip selects on third or sixth port
		if (chipSelectsToThird) begin
			altSel[2] = 8'hFF; // RULE_10
			altVal[2] = externalChipSelects;
		end
		if (chipSelectsToSixth) begin
			altSel[5] = 8'hFF; // RULE_10
			altVal[5] = externalChipSelects;
		end
		// fourth port dedicated inputs never drive
		forceIn[3] = {4'h0, dedicatedInputEn}; // RULE_13
		// latched address out on fifth to seventh ports
		altSel[4]  = st.control[4]; // RULE_19
		altVal[4]  = latchedAddress[7:0];
		forceOe[4] = st.control[4]; // RULE_17
		altSel[5]  = altSel[5] | st.control[5];
		altVal[5]  = (altVal[5] & ~st.control[5])
			| (latchedAddress[7:0] & st.control[5]);
		forceOe[5] = st.control[5]; // RULE_17
		altSel[6]  = st.control[6];
		altVal[6]  = latchedAddress[15:8];
		forceOe[6] = st.control[6]; // RULE_17
		// fifth port serial test port, standby supply and battery flag
		if (serialPortEn) begin
			forceIn[4][2:0] = 3'h7; // RULE_15
			altSel[4][3]    = 1'b1;
			altVal[4][3]    = serialDataOut;
			forceOe[4][3]   = 1'b1;
		end
		if (batteryStandbyEn) begin
			forceIn[4][6] = 1'b1; // RULE_15
		end
		if (batteryOnRouteEn) begin
			altSel[4][7]  = 1'b1; // RULE_15
			altVal[4][7]  = batteryOnIndicator;
			forceOe[4][7] = 1'b1;
		end
		// data port for a non-multiplexed bus, peripheral mode alike
		if (dataPortOn) begin
			altSel[5]  = 8'hFF; // RULE_16
			altVal[5]  = busDataOut[7:0];
			forceOe[5] = {8{busDataDrive}};
			forceIn[5] = {8{~busDataDrive}};
			altSel[6]  = 8'hFF; // RULE_16
			altVal[6]  = busDataOut[15:8];
			forceOe[6] = {8{busDataDrive}};
			forceIn[6] = {8{~busDataDrive}};
		end
		// reset pattern overrides the data port
		if (patternOn) begin
			altSel[5]  = 8'hFF; // RULE_20
			altVal[5]  = resetPattern[7:0];
			forceOe[5] = 8'hFF;
			forceIn[5] = 8'h00;
			altSel[6]  = 8'hFF;
			altVal[6]  = resetPattern[15:8];
			forceOe[6] = 8'hFF;
			forceIn[6] = 8'h00;
		end
		// open-drain capable ports take their drive bits
		openDrain[0] = st.drive[0]; // RULE_11
		openDrain[1] = st.drive[1];
		openDrain[3] = st.drive[3];
		openDrain[4] = st.drive[4];
		openDrain[6] = st.drive[6];
	end

	// one driver slice per port
	for (genvar p = 0; p < 7; p++) begin : gSlice
		pdr_slice_if sl ();

		assign sl.latch     = st.outLatch[p];
		assign sl.dirBits   = st.direction[p]; // RULE_18
		assign sl.oeTerm    = oeTerm[p];
		assign sl.altSel    = altSel[p];
		assign sl.altVal    = altVal[p];
		assign sl.forceOe   = forceOe[p];
		assign sl.forceIn   = forceIn[p];
		assign sl.openDrain = openDrain[p];
		assign pinOut[p]    = sl.pinOut;
		assign pinOe[p]     = sl.pinOe;
		assign drvEn[p]     = sl.drvEn;

		pdr_port_slice #(
			.PIN_MASK (PORT_MASKS[p])
		) uSlice (
			.sl (sl)
		);
	end

	// read mux; missing registers and pins read zero
	always_comb begin
		portMask = (selPort == 3'h7) ? 8'h00 : PORT_MASKS[selPort]; // RULE_22
		readVal  = 8'h00;
		if (selPort != 3'h7) begin
			unique case (selReg)
				`PDR_SEL_PIN_INPUT:    readVal = pinIn[selPort]; // RULE_01
				`PDR_SEL_OUTPUT_LATCH: readVal = st.outLatch[selPort]; // RULE_03
				`PDR_SEL_DIRECTION:    readVal = st.direction[selPort];
				`PDR_SEL_CONTROL:      readVal = st.control[selPort];
				`PDR_SEL_DRIVE:        readVal = st.drive[selPort];
				`PDR_SEL_OUTPUT_CELL: begin
					if (selPort == `PDR_PORT_A) begin
						readVal = st.outCell[7:0]; // RULE_04
					end else if (selPort == `PDR_PORT_B) begin
						readVal = st.outCell[15:8]; // RULE_06
					end
				end
				`PDR_SEL_LOAD_BLOCK: begin
					if (selPort == `PDR_PORT_A) begin
						readVal = st.loadBlock[7:0]; // RULE_06
					end else if (selPort == `PDR_PORT_B) begin
						readVal = st.loadBlock[15:8];
					end
				end
				`PDR_SEL_INPUT_CELL: begin
					if (selPort == `PDR_PORT_A) begin
						readVal = st.inCell[7:0]; // RULE_07
					end else if (selPort == `PDR_PORT_B) begin
						readVal = st.inCell[15:8];
					end else if (selPort == `PDR_PORT_C) begin
						readVal = st.inCell[23:16];
					end
				end
				`PDR_SEL_DRIVER_ENABLE: begin
					if (selPort == `PDR_PORT_A || selPort == `PDR_PORT_B
						|| selPort == `PDR_PORT_C
						|| selPort == `PDR_PORT_F) begin
						readVal = drvEn[selPort]; // RULE_09
					end
				end
				default: readVal = 8'h00;
			endcase
		end
		readVal = readVal & portMask; // RULE_22
	end

	// next state
	always_comb begin
		next_st = st;
		// output cells follow the array on each logic clock enable
		if (cellClkEn) begin
			next_st.outCell = cellNext;
		end
		// input cells capture pins of the first three ports
		for (int b = 0; b < 24; b++) begin
			if (inCellLoad[b]) begin
				next_st.inCell[b] = pinIn[b / 8][b % 8]; // RULE_07
			end
		end
		// host read data registered one cycle after the strobe
		if (hostRead && regBlockOn) begin
			next_st.rdata = readVal;
		end else if (hostRead) begin
			next_st.rdata = 8'h00; // RULE_14
		end
		// host writes, refused while the register block is disabled
		if (hostWrite && regBlockOn && selPort != 3'h7) begin
			unique case (selReg)
				`PDR_SEL_OUTPUT_LATCH:
					next_st.outLatch[selPort] = hostWdata
						& PORT_MASKS[selPort]; // RULE_03
				`PDR_SEL_DIRECTION:
					next_st.direction[selPort] = hostWdata
						& PORT_MASKS[selPort]; // RULE_18
				`PDR_SEL_CONTROL: begin
					if (selPort >= `PDR_PORT_E) begin
						next_st.control[selPort] = hostWdata; // RULE_19
					end
				end
				`PDR_SEL_DRIVE:
					next_st.drive[selPort] = hostWdata
						& PORT_MASKS[selPort]; // RULE_22
				`PDR_SEL_OUTPUT_CELL: begin
					// blocked bits keep their value or take the array load, host wins the rest
					if (selPort == `PDR_PORT_A) begin
						next_st.outCell[7:0] = (next_st.outCell[7:0]
							& st.loadBlock[7:0])
							| (hostWdata & ~st.loadBlock[7:0]); // RULE_05
					end else if (selPort == `PDR_PORT_B) begin
						next_st.outCell[15:8] = (next_st.outCell[15:8]
							& st.loadBlock[15:8])
							| (hostWdata & ~st.loadBlock[15:8]); // RULE_04
					end
				end
				`PDR_SEL_LOAD_BLOCK: begin
					if (selPort == `PDR_PORT_A) begin
						next_st.loadBlock[7:0] = hostWdata; // RULE_06
					end else if (selPort == `PDR_PORT_B) begin
						next_st.loadBlock[15:8] = hostWdata;
					end
				end
				default: next_st = next_st;
			endcase
		end
	end

	// state register, everything input and unblocked after reset
	always_ff @(posedge clk) begin
		if (rst) begin
			st.outLatch  <= '0;
			st.direction <= '0; // RULE_18
			st.control   <= '0; // RULE_19
			st.drive     <= '0;
			st.outCell   <= `PDR_RST_CELLS;
			st.loadBlock <= `PDR_RST_CELLS; // RULE_05
			st.inCell    <= `PDR_RST_INCEL;
			st.rdata     <= `PDR_RST_BYTE;
		end else begin
			st <= next_st;
		end
	end
endmodule

// file: test/pdr_port_data_monitor.sv
/*
 * Checker of the port data register block, bound to its top module.
 * Assumes one clock and a synchronous active-high reset.
 */
module pdr_port_data_monitor
	import pdr_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [6:0]  hostAddr,
	input wire logic        hostWrite,
	input wire logic        hostRead,
	input wire logic [7:0]  hostWdata,
	input wire logic [7:0]  hostRdata,
	input wire pdr_bytes_t  pinIn,
	input wire pdr_bytes_t  pinOut,
	input wire pdr_bytes_t  pinOe,
	input wire pdr_bytes_t  oeTerm,
	input wire logic [23:0] inCellLoad,
	input wire logic [23:0] inputCellBus,
	input wire logic [15:0] outputCellBus,
	input wire logic        chipSelectsToThird,
	input wire logic [3:0]  dedicatedInputEn,
	input wire logic        chipSelectHigh,
	input wire logic        memoryDisable,
	input wire logic        serialPortEn,
	input wire logic        batteryOnRouteEn
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// read answers one cycle after the read edge
	a_pin_read_back:
	assert property (hostRead && hostAddr == 7'h00 && !chipSelectHigh
		|=> hostRdata == $past(pinIn[0])) else $error("pin read wrong");
	a_latch_read_back:
	assert property ($past(hostWrite && hostAddr == 7'h21 && !chipSelectHigh)
		&& hostRead && hostAddr == 7'h21 && !chipSelectHigh
		|=> hostRdata == $past(hostWdata, 2)) else $error("latch read wrong");
	a_cell_read_back:
	assert property (hostRead && hostAddr == 7'h05 && !chipSelectHigh
		|=> hostRdata == $past(outputCellBus[7:0])) else $error("cell read");
	a_status_is_oe:
	assert property (hostRead && hostAddr == 7'h28 && !chipSelectHigh
		|=> hostRdata == $past(pinOe[2])) else $error("status read wrong");
	a_unmapped_zero:
	assert property (hostRead && hostAddr[6:4] == 3'h7
		|=> hostRdata == 8'h00) else $error("unmapped read not zero");
	a_select_refuses:
	assert property (hostRead && chipSelectHigh
		|=> hostRdata == 8'h00) else $error("deselected read not zero");

	// pin side relations
	a_latch_drives_pin:
	assert property ($past(hostWrite && hostAddr == 7'h21 && !chipSelectHigh)
		&& oeTerm[2] == 8'hFF && !chipSelectsToThird
		|-> pinOe[2] == 8'hFF && pinOut[2] == $past(hostWdata))
		else $error("latch not driven");
	a_input_cell_load:
	assert property (inCellLoad[15:8] == 8'hFF
		|=> inputCellBus[15:8] == $past(pinIn[1])) else $error("cell load");
	a_select_from_pin:
	assert property (dedicatedInputEn[2] |-> chipSelectHigh == pinIn[3][2]
		&& memoryDisable == pinIn[3][2] && !pinOe[3][2])
		else $error("select pin wrong");
	a_reset_idle:
	assert property ($past(rst) && !serialPortEn && !batteryOnRouteEn
		|-> pinOe[4] == 8'h00 && hostRdata == 8'h00)
		else $error("not idle after reset");
endmodule

bind pdr_port_data pdr_port_data_monitor mon (.*);

// file: test/pdr_host_model.sv
/*
 * Host model: single-cycle register reads and writes.
 * Assumes tasks are called one at a time from one process.
 */
module pdr_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] hostRdata,
	output logic      [6:0] hostAddr,
	output logic            hostWrite,
	output logic            hostRead,
	output logic      [7:0] hostWdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle bus at time zero
	initial begin
		hostAddr = 7'h00;
		hostWrite = 1'b0;
		hostRead = 1'b0;
		hostWdata = 8'h00;
	end

	// one write; released data is scrambled
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		hostAddr <= a;
		hostWdata <= d;
		hostWrite <= 1'b1;
		@(posedge clk);
		hostWrite <= 1'b0;
		hostWdata <= ~d;
	endtask

	// one read, data taken once it stands
	task automatic rd(input logic [6:0] a, output logic [7:0] q);
		@(posedge clk);
		hostAddr <= a;
		hostRead <= 1'b1;
		@(posedge clk);
		hostRead <= 1'b0;
		@(negedge clk);
		q = hostRdata;
	endtask

	// write then read of one register, back to back
	task automatic wrrd(input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk);
		hostAddr <= a;
		hostWdata <= d;
		hostWrite <= 1'b1;
		@(posedge clk);
		hostWrite <= 1'b0;
		hostWdata <= ~d;
		hostRead <= 1'b1;
		@(posedge clk);
		hostRead <= 1'b0;
		@(negedge clk);
		q = hostRdata;
	endtask
endmodule

// file: test/pdr_port_data_test.sv
/*
 * Self-checking bench of the port data register block.
 * Assumes the host model and the bound checker are compiled before it.
 */
module pdr_port_data_test
	import pdr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rst, hostWrite, hostRead;
	logic [6:0]  hostAddr;
	logic [7:0]  hostWdata, hostRdata;
	pdr_bytes_t  pinIn, pinOut, pinOe, oeTerm;
	logic [15:0] cellNext, outputCellBus, busDataOut, latchedAddress;
	logic [15:0] resetPattern, busDataIn, fastSlew;
	logic [23:0] inCellLoad, inputCellBus;
	logic [7:0]  externalChipSelects, firstGroupRoute, secondGroupRoute;
	logic [3:0]  dedicatedInputEn;
	logic [2:0]  serialPortIn;
	logic        cellClkEn, chipSelectsToThird, chipSelectsToSixth;
	logic        serialPortEn, serialDataOut, batteryStandbyEn;
	logic        batteryOnRouteEn, batteryOnIndicator, dataPortEn;
	logic        peripheralModeEn, busDataDrive, resetPatternEn;
	logic        hostResetActive, busCycleActive, addressStrobe;
	logic        logicClockInput, chipSelectHigh, highByteWriteEnable;
	logic        memoryDisable;
	int          n_mismatch, n_compared;

	pdr_host_model host (.clk(clk), .hostRdata(hostRdata),
		.hostAddr(hostAddr), .hostWrite(hostWrite), .hostRead(hostRead),
		.hostWdata(hostWdata));
	pdr_port_data uut (.*);

	// free-running 10 MHz clock
	always #50 clk = ~clk;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rc(input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] q;
		host.rd(a, q);
		chk(q, exp);
	endtask

	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic t_pins;
		logic [7:0] q;
		rc(7'h06, 8'h00);
		rc(7'h22, 8'h00);
		@(posedge clk);
		pinIn[0] <= 8'h69;
		pinIn[2] <= 8'h3C;
		pinIn[3] <= 8'hFF;
		rc(7'h00, 8'h69);
		rc(7'h20, 8'h3C);
		rc(7'h30, 8'h0F);
		host.wr(7'h22, 8'h0F);
		host.wr(7'h21, 8'hA5);
		@(negedge clk);
		chk(pinOe[2], 8'h0F);
		chk(pinOut[2] & 8'h0F, 8'h05);
		rc(7'h28, 8'h0F);
		rc(7'h48, 8'h00);
		@(posedge clk);
		oeTerm[2] <= 8'hFF;
		host.wrrd(7'h21, 8'h5A, q);
		chk(q, 8'h5A);
		chk(pinOe[2], 8'hFF);
		host.wr(7'h31, 8'hFF);
		rc(7'h31, 8'h0F);
		rc(7'h70, 8'h00);
	endtask

	task automatic t_cells;
		host.wr(7'h05, 8'h5A);
		rc(7'h05, 8'h5A);
		host.wr(7'h06, 8'hF0);
		rc(7'h06, 8'hF0);
		host.wr(7'h05, 8'hFF);
		rc(7'h05, 8'h5F);
		host.wr(7'h15, 8'h33);
		rc(7'h15, 8'h33);
		host.wr(7'h25, 8'h77);
		rc(7'h25, 8'h00);
		@(posedge clk);
		cellNext <= 16'h3CA0;
		cellClkEn <= 1'b1;
		pinIn[1] <= 8'h96;
		inCellLoad <= 24'h00FF00;
		@(posedge clk);
		cellClkEn <= 1'b0;
		inCellLoad <= 24'h000000;
		pinIn[1] <= 8'h00;
		rc(7'h05, 8'hA0);
		rc(7'h15, 8'h3C);
		rc(7'h17, 8'h96);
	endtask

	task automatic t_select;
		host.wr(7'h01, 8'h77);
		@(posedge clk);
		pinIn[3] <= 8'hF5;
		dedicatedInputEn <= 4'hF;
		@(negedge clk);
		chk({7'h00, memoryDisable}, 8'h01);
		chk({6'h00, addressStrobe, logicClockInput}, 8'h02);
		chk({7'h00, highByteWriteEnable}, 8'h00);
		host.wr(7'h01, 8'h11);
		rc(7'h01, 8'h00);
		@(posedge clk);
		pinIn[3] <= 8'h00;
		rc(7'h01, 8'h77);
	endtask

	task automatic t_bus;
		@(posedge clk);
		resetPattern <= 16'hBEEF;
		{resetPatternEn, hostResetActive, dataPortEn} <= 3'h7;
		busDataDrive <= 1'b1;
		busDataOut <= 16'hC3A5;
		@(negedge clk);
		chk(pinOut[5], 8'hEF);
		chk(pinOut[6], 8'hBE);
		@(posedge clk);
		busCycleActive <= 1'b1;
		@(negedge clk);
		chk(pinOut[6], 8'hC3);
		@(posedge clk);
		busDataDrive <= 1'b0;
		pinIn[5] <= 8'h12;
		pinIn[6] <= 8'h34;
		@(negedge clk);
		chk(busDataIn[15:8], 8'h34);
		chk(pinOe[6], 8'h00);
		chk(busDataIn[7:0], 8'h12);
		@(posedge clk);
		{dataPortEn, peripheralModeEn, busDataDrive} <= 3'h3;
		@(negedge clk);
		chk(pinOe[5], 8'hFF);
		chk(pinOut[5], 8'hA5);
	endtask

	task automatic t_misc;
		@(posedge clk);
		latchedAddress <= 16'h1234;
		{serialPortEn, serialDataOut, chipSelectsToThird} <= 3'h7;
		{batteryStandbyEn, batteryOnRouteEn, batteryOnIndicator} <= 3'h7;
		{peripheralModeEn, busDataDrive, chipSelectsToSixth} <= 3'h1;
		pinIn[4] <= 8'h05;
		oeTerm[4] <= 8'h40;
		externalChipSelects <= 8'h5A;
		firstGroupRoute <= 8'hFF;
		secondGroupRoute <= 8'hFF;
		host.wr(7'h43, 8'h30);
		host.wr(7'h24, 8'h81);
		host.wr(7'h54, 8'h42);
		@(negedge clk);
		chk(pinOut[4] & 8'hB8, 8'hB8);
		chk(pinOe[4] & 8'hF8, 8'hB8);
		chk({5'h00, serialPortIn}, 8'h05);
		chk(pinOut[2], 8'h5A);
		chk(pinOut[5], 8'h5A);
		chk(pinOut[0], 8'hA0);
		chk(pinOut[1], 8'h3C);
		chk(fastSlew[7:0], 8'h81);
		chk(fastSlew[15:8], 8'h42);
		host.wr(7'h02, 8'hFF);
		host.wr(7'h04, 8'hFF);
		@(negedge clk);
		chk(pinOut[0], 8'h00);
		chk(pinOe[0], 8'h5F);
		rc(7'h08, 8'hFF);
	endtask

	// main sequence: reset for three cycles, then the scenarios
	initial begin
		{pinIn, oeTerm, cellNext, busDataOut, latchedAddress, resetPattern,
			inCellLoad, externalChipSelects, firstGroupRoute,
			secondGroupRoute, dedicatedInputEn, cellClkEn,
			chipSelectsToThird, chipSelectsToSixth, serialPortEn,
			serialDataOut, batteryStandbyEn, batteryOnRouteEn,
			batteryOnIndicator, dataPortEn, peripheralModeEn, busDataDrive,
			resetPatternEn, hostResetActive, busCycleActive} = '0;
		clk = 1'b0;
		rst = 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_pins;
		t_cells;
		t_select;
		t_bus;
		t_misc;
		end_of_test;
	end

	// run limit cuts a hang short
	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		end_of_test;
	end
endmodule
